// ---- hdl/remote_command_parser.sv ----
// remote command interpreter: key enables, settings, query answers
`timescale 1ns/1ps
module remote_command_parser (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cmd_valid_i,
  input  wire gauge_cmd_pkg::cmd_e        cmd_i,
  input  wire gauge_cmd_pkg::field_s      arg_i,
  output logic                            cmd_ready_o,
  input  wire logic                       error_i,
  input  wire logic                       default_i,
  input  wire logic                       dev_clear_i,
  input  wire logic                       sel_clear_i,
  input  wire logic                       power_up_i,
  input  wire logic                       span_sw_i,
  input  wire logic                       elev_sw_i,
  input  wire logic                       null_sw_i,
  input  wire logic                       units_metric_i,
  input  wire logic                       sensor_abs_i,
  input  wire gauge_cmd_pkg::option_e     option_i,
  input  wire gauge_cmd_pkg::meas_mode_e  mode_i,
  input  wire gauge_cmd_pkg::readings_s   readings_i,
  output gauge_cmd_pkg::settings_s        settings_o,
  output logic                            elev_metric_o,
  output logic                            master_en_o,
  output logic                            elev_en_o,
  output logic                            offset_en_o,
  output logic                            null_en_o,
  output logic                            elev_disabled_o,
  output logic                            err_o,
  output gauge_cmd_pkg::err_e             err_code_o,
  output logic                            save_o,
  output logic [7:0]                      resp_data_o,
  output logic                            resp_valid_o,
  input  wire logic                       resp_ready_i
);
  typedef enum logic [2:0] {S_IDLE, S_FIELD, S_SEP1, S_SEP2, S_TEXT, S_CR, S_LF} st_e;
  typedef enum logic [3:0] {
    T_NONE, T_SERIAL, T_DIGITAL, T_DIG_ANALOG, T_NO_OPT, T_ABS, T_GAUGE, T_FEET, T_METERS
  } txt_e;

  st_e                      st_q;
  gauge_cmd_pkg::cmd_e      qry_q;
  gauge_cmd_pkg::meas_mode_e mode_q;
  gauge_cmd_pkg::out_fmt_t  fmt_q;
  gauge_cmd_pkg::readings_s rd_q;
  gauge_cmd_pkg::settings_s cfg_q;
  gauge_cmd_pkg::settings_s sav_q;
  gauge_cmd_pkg::field_s    fld;
  gauge_cmd_pkg::out_fmt_t  fld_fmt;
  gauge_cmd_pkg::err_e      err_d;
  txt_e                     tail_q;
  logic [1:0]               nf_q;
  logic [1:0]               k_q;
  logic [4:0]               idx_q;
  logic [7:0]               data_q;
  logic                     valid_q;
  logic [7:0]               fld_char;
  logic                     fld_last;
  logic [7:0]               txt_char;
  logic                     txt_last;
  logic [7:0]               char_d;
  logic                     cmd_fire;
  logic                     resp_fire;
  logic                     clear_ev;
  logic                     span_sw_q;
  logic                     elev_sw_q;
  logic                     master_q;
  logic                     elev_q;
  logic                     offset_q;
  logic                     null_q;
  logic                     disabled_q;
  logic                     err_q;
  gauge_cmd_pkg::err_e      code_q;

  function automatic logic is_query(input gauge_cmd_pkg::cmd_e c);
    is_query = (c >= gauge_cmd_pkg::CMD_READ);
  endfunction

  // count of numeric fields in an answer
  function automatic logic [1:0] field_count(input gauge_cmd_pkg::cmd_e c,
      input gauge_cmd_pkg::meas_mode_e m, input gauge_cmd_pkg::out_fmt_t f);
    if (c == gauge_cmd_pkg::CMD_OPTION_Q || c == gauge_cmd_pkg::CMD_TYPE_Q)
      field_count = 2'h0;
    else if (c != gauge_cmd_pkg::CMD_READ)
      field_count = 2'h1;
    else if (f == gauge_cmd_pkg::FMT_COUNTS)
      field_count = 2'h2;
    else if (m == gauge_cmd_pkg::MODE_PEAK)
      field_count = 2'h3;
    else if (m == gauge_cmd_pkg::MODE_RATE)
      field_count = 2'h2;
    else
      field_count = 2'h1;
  endfunction

  assign cmd_ready_o = (st_q == S_IDLE);
  assign cmd_fire = cmd_valid_i && cmd_ready_o;
  assign resp_fire = valid_q && resp_ready_i;
  assign resp_valid_o = valid_q;
  assign resp_data_o = data_q;
  assign settings_o = cfg_q;
  assign elev_metric_o = units_metric_i;
  assign master_en_o = master_q;
  assign elev_en_o = elev_q;
  assign offset_en_o = offset_q;
  assign null_en_o = null_q;
  assign elev_disabled_o = disabled_q;
  assign err_o = err_q;
  assign err_code_o = code_q;

  // argument checks; key commands never fault
  always_comb begin
    logic [23:0] top;
    top = arg_i.bcd[27:4];
    err_d = gauge_cmd_pkg::ERR_NONE;
    if (cmd_fire) begin
      unique case (cmd_i)
        gauge_cmd_pkg::CMD_SPAN_SET:
          if (!master_q) err_d = gauge_cmd_pkg::ERR_MASTER_OFF;
        gauge_cmd_pkg::CMD_TARE_SET:
          if (!(offset_q || master_q))
            err_d = gauge_cmd_pkg::ERR_OFFSET_OFF;
          else if (arg_i.int_digits > 3'h2 ||
                   (arg_i.int_digits == 3'h2 && top > gauge_cmd_pkg::TARE_MAX_BCD))
            err_d = gauge_cmd_pkg::ERR_PARAM_INVALID;
        gauge_cmd_pkg::CMD_ELEV_SET:
          if (!(elev_q || master_q)) err_d = gauge_cmd_pkg::ERR_ELEV_OFF;
        gauge_cmd_pkg::CMD_RFILTER_SET:
          if (arg_i.neg || arg_i.int_digits > gauge_cmd_pkg::RFILTER_INT ||
              arg_i.bcd[11:0] != 12'h000)
            err_d = gauge_cmd_pkg::ERR_PARAM_INVALID;
        gauge_cmd_pkg::CMD_FORMAT_SET:
          if (arg_i.bcd[27:24] > 4'h2) err_d = gauge_cmd_pkg::ERR_PARAM_INVALID;
        default: err_d = gauge_cmd_pkg::ERR_NONE;
      endcase
    end
  end

  // any of these withdraws every key enable
  assign clear_ev = error_i || default_i || dev_clear_i || sel_clear_i || power_up_i ||
                    (err_d != gauge_cmd_pkg::ERR_NONE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      code_q <= gauge_cmd_pkg::ERR_NONE;
      disabled_q <= 1'b0;
    end else begin
      err_q <= (err_d != gauge_cmd_pkg::ERR_NONE);
      if (err_d != gauge_cmd_pkg::ERR_NONE) code_q <= err_d;
      disabled_q <= (err_d == gauge_cmd_pkg::ERR_ELEV_OFF);
    end
  end

  // key enables; a clear in the same cycle as a key wins
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      span_sw_q <= 1'b0;
      elev_sw_q <= 1'b0;
      master_q <= 1'b0;
      elev_q <= 1'b0;
      offset_q <= 1'b0;
      null_q <= 1'b0;
    end else begin
      span_sw_q <= span_sw_i;
      elev_sw_q <= elev_sw_i;
      if (clear_ev || !span_sw_i)
        master_q <= 1'b0;
      else if (cmd_fire && cmd_i == gauge_cmd_pkg::CMD_MASTER_KEY)
        master_q <= 1'b1;
      if (clear_ev || !elev_sw_i)
        elev_q <= 1'b0;
      else if (cmd_fire && cmd_i == gauge_cmd_pkg::CMD_ELEV_KEY)
        elev_q <= 1'b1;
      if (clear_ev)
        offset_q <= 1'b0;
      else if (cmd_fire && cmd_i == gauge_cmd_pkg::CMD_OFFSET_KEY)
        offset_q <= 1'b1;
      if (clear_ev)
        null_q <= 1'b0;
      else if (cmd_fire && cmd_i == gauge_cmd_pkg::CMD_NULL_KEY && null_sw_i)
        null_q <= 1'b1;
    end
  end

  // working settings are volatile; power-up reloads the saved copy
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= gauge_cmd_pkg::CFG_RST;
      sav_q <= gauge_cmd_pkg::CFG_RST;
      save_o <= 1'b0;
    end else begin
      save_o <= cmd_fire && cmd_i == gauge_cmd_pkg::CMD_SAVE;
      if (power_up_i)
        cfg_q <= sav_q;
      else if (cmd_fire && err_d == gauge_cmd_pkg::ERR_NONE) begin
        unique case (cmd_i)
          gauge_cmd_pkg::CMD_SAVE: sav_q <= cfg_q;
          gauge_cmd_pkg::CMD_FORMAT_SET: cfg_q.fmt <= arg_i.bcd[25:24];
          gauge_cmd_pkg::CMD_RFILTER_SET: cfg_q.rfilter <= arg_i;
          gauge_cmd_pkg::CMD_TARE_SET: cfg_q.tare <= arg_i;
          gauge_cmd_pkg::CMD_ELEV_SET: cfg_q.elev <= arg_i;
          gauge_cmd_pkg::CMD_ELEV_ON: cfg_q.elev_apply <= 1'b1;
          gauge_cmd_pkg::CMD_ELEV_OFF: cfg_q.elev_apply <= 1'b0;
          gauge_cmd_pkg::CMD_SPAN_SET: begin
            cfg_q.span <= arg_i;
            cfg_q.span.neg <= 1'b0;
            cfg_q.span.int_digits <= 3'h1;
            if (arg_i.neg || (arg_i.int_digits == 3'h1 &&
                              arg_i.bcd[27:4] < gauge_cmd_pkg::SPAN_MIN_BCD))
              cfg_q.span.bcd <= {gauge_cmd_pkg::SPAN_MIN_BCD, 4'h0};
            else if (arg_i.int_digits != 3'h1 ||
                     arg_i.bcd[27:4] > gauge_cmd_pkg::SPAN_MAX_BCD)
              cfg_q.span.bcd <= {gauge_cmd_pkg::SPAN_MAX_BCD, 4'h0};
          end
          default: cfg_q <= cfg_q;
        endcase
      end
    end
  end

  // field feeding the renderer for the current answer position
  always_comb begin
    fld = rd_q.cur;
    fld_fmt = gauge_cmd_pkg::FMT_DECIMAL;
    unique case (qry_q)
      gauge_cmd_pkg::CMD_READ: begin
        fld_fmt = fmt_q;
        if (fmt_q == gauge_cmd_pkg::FMT_COUNTS)
          fld = (k_q == 2'h0) ? rd_q.cnt_press : rd_q.cnt_temp;
        else if (mode_q == gauge_cmd_pkg::MODE_PEAK)
          fld = (k_q == 2'h0) ? rd_q.min : (k_q == 2'h1) ? rd_q.cur : rd_q.max;
        else if (k_q == 2'h1)
          fld = rd_q.rate;
      end
      gauge_cmd_pkg::CMD_RFILTER_Q: fld = cfg_q.rfilter;
      gauge_cmd_pkg::CMD_SPAN_Q: fld = cfg_q.span;
      gauge_cmd_pkg::CMD_TARE_Q: fld = cfg_q.tare;
      gauge_cmd_pkg::CMD_ELEV_Q: fld = cfg_q.elev;
      gauge_cmd_pkg::CMD_RANGE_LOW_Q: fld = rd_q.range_low;
      default: fld = rd_q.cur;
    endcase
  end

  field_text u_field_text (
    .fld_i  (fld),
    .fmt_i  (fld_fmt),
    .idx_i  (idx_q[3:0]),
    .char_o (fld_char),
    .last_o (fld_last)
  );

  // fixed answer texts, right aligned in a 17 character slot
  always_comb begin
    logic [135:0] s;
    logic [4:0]   n;
    logic [135:0] sh;
    s = {17{8'h20}};
    n = 5'h1;
    unique case (tail_q)
      T_SERIAL: begin s = 136'("SERIAL"); n = 5'd6; end
      T_DIGITAL: begin s = 136'("BCD"); n = 5'd3; end
      T_DIG_ANALOG: begin s = 136'("BCD/ANALOG"); n = 5'd10; end
      T_NO_OPT: begin s = 136'("NONE"); n = 5'd4; end
      T_ABS: begin s = 136'("ABSOLUTE PRESSURE"); n = 5'd17; end
      T_GAUGE: begin s = 136'("GAUGE PRESSURE"); n = 5'd14; end
      T_FEET: begin s = 136'(" FEET"); n = 5'd5; end
      T_METERS: begin s = 136'(" METERS"); n = 5'd7; end
      default: begin s = {17{8'h20}}; n = 5'h1; end
    endcase
    sh = s >> {(n - 5'h1 - idx_q), 3'b000};
    txt_char = sh[7:0];
    txt_last = (idx_q == n - 5'h1);
  end

  always_comb begin
    unique case (st_q)
      S_FIELD: char_d = fld_char;
      S_SEP1: char_d = gauge_cmd_pkg::CHAR_COMMA;
      S_SEP2: char_d = gauge_cmd_pkg::CHAR_SPACE;
      S_TEXT: char_d = txt_char;
      S_CR: char_d = gauge_cmd_pkg::CHAR_CR;
      S_LF: char_d = gauge_cmd_pkg::CHAR_LF;
      default: char_d = 8'h00;
    endcase
  end

  // query start latches a reading snapshot so fields stay coherent
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qry_q <= gauge_cmd_pkg::CMD_READ;
      mode_q <= gauge_cmd_pkg::MODE_PRESSURE;
      fmt_q <= gauge_cmd_pkg::FMT_DECIMAL;
      rd_q <= '0;
      tail_q <= T_NONE;
      nf_q <= 2'h0;
    end else if (cmd_fire && is_query(cmd_i)) begin
      qry_q <= cmd_i;
      mode_q <= mode_i;
      fmt_q <= cfg_q.fmt;
      rd_q <= readings_i;
      nf_q <= field_count(cmd_i, mode_i, cfg_q.fmt);
      unique case (cmd_i)
        gauge_cmd_pkg::CMD_OPTION_Q:
          unique case (option_i)
            gauge_cmd_pkg::OPT_SERIAL: tail_q <= T_SERIAL;
            gauge_cmd_pkg::OPT_DIGITAL: tail_q <= T_DIGITAL;
            gauge_cmd_pkg::OPT_DIGITAL_ANALOG: tail_q <= T_DIG_ANALOG;
            default: tail_q <= T_NO_OPT;
          endcase
        gauge_cmd_pkg::CMD_TYPE_Q: tail_q <= sensor_abs_i ? T_ABS : T_GAUGE;
        gauge_cmd_pkg::CMD_ELEV_Q: tail_q <= units_metric_i ? T_METERS : T_FEET;
        default: tail_q <= T_NONE;
      endcase
    end
  end

  // one character per load cycle, then waits for the reader
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      k_q <= 2'h0;
      idx_q <= 5'h0;
      data_q <= 8'h00;
      valid_q <= 1'b0;
    end else if (st_q == S_IDLE) begin
      k_q <= 2'h0;
      idx_q <= 5'h0;
      if (cmd_fire && is_query(cmd_i))
        st_q <= (field_count(cmd_i, mode_i, cfg_q.fmt) == 2'h0) ? S_TEXT : S_FIELD;
    end else if (!valid_q) begin
      data_q <= char_d;
      valid_q <= 1'b1;
    end else if (resp_fire) begin
      valid_q <= 1'b0;
      unique case (st_q)
        S_FIELD:
          if (!fld_last)
            idx_q <= idx_q + 5'h1;
          else begin
            idx_q <= 5'h0;
            if (k_q + 2'h1 < nf_q) st_q <= S_SEP1;
            else st_q <= (tail_q == T_NONE) ? S_CR : S_TEXT;
          end
        S_SEP1: st_q <= S_SEP2;
        S_SEP2: begin
          st_q <= S_FIELD;
          k_q <= k_q + 2'h1;
        end
        S_TEXT:
          if (txt_last) st_q <= S_CR;
          else idx_q <= idx_q + 5'h1;
        S_CR: st_q <= S_LF;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cr_taken;
    resp_fire && resp_data_o == gauge_cmd_pkg::CHAR_CR;
  endsequence
  sequence s_lf_shown;
    resp_valid_o && resp_data_o == gauge_cmd_pkg::CHAR_LF;
  endsequence
  sequence s_span_off;
    span_sw_q && !span_sw_i;
  endsequence
  sequence s_elev_off;
    elev_sw_q && !elev_sw_i;
  endsequence

  a_crlf_tail: assert property (s_cr_taken |-> ##[1:2] s_lf_shown)
    else $error("line feed did not follow carriage return");
  a_lf_then_idle: assert property (s_lf_shown and resp_fire |=> cmd_ready_o)
    else $error("not idle after line feed");
  // switch is judged at the taking edge; it may legally drop right after
  a_master_span: assert property ($rose(master_q) |-> $past(span_sw_i)
      && $past(cmd_i) == gauge_cmd_pkg::CMD_MASTER_KEY)
    else $error("master enable without span switch");
  a_master_clear: assert property ((s_span_off or clear_ev) |=> !master_q)
    else $error("master enable survived a clear");
  a_elev_grant: assert property ($rose(elev_q) |-> $past(elev_sw_i))
    else $error("elevation enable without its switch");
  a_elev_clear: assert property ((s_elev_off or clear_ev) |=> !elev_q)
    else $error("elevation enable survived a clear");
  a_offset_hold: assert property (offset_q && !clear_ev |=> offset_q)
    else $error("offset enable dropped without cause");
  a_null_hold: assert property (null_q && !clear_ev |=> null_q)
    else $error("null enable dropped without cause");
  a_elev_reject: assert property (err_d == gauge_cmd_pkg::ERR_ELEV_OFF
      |=> elev_disabled_o && $stable(cfg_q.elev) && code_q == gauge_cmd_pkg::ERR_ELEV_OFF)
    else $error("elevation accepted while disabled");
  a_span_limit: assert property (cfg_q.span.bcd[27:4] >= gauge_cmd_pkg::SPAN_MIN_BCD
      && cfg_q.span.bcd[27:4] <= gauge_cmd_pkg::SPAN_MAX_BCD)
    else $error("span factor out of limits");
  a_span_master: assert property (cmd_fire && cmd_i == gauge_cmd_pkg::CMD_SPAN_SET
      && !master_q |=> err_o && code_q == gauge_cmd_pkg::ERR_MASTER_OFF && $stable(cfg_q.span))
    else $error("span change without master enable");
  a_fmt_legal: assert property (cfg_q.fmt <= gauge_cmd_pkg::FMT_EXPONENT)
    else $error("illegal output format");
endmodule

// ---- hdl/gauge_cmd_pkg.sv ----
// shared types and constants of the remote command interpreter
package gauge_cmd_pkg;
  typedef logic [1:0] out_fmt_t;
  localparam out_fmt_t FMT_DECIMAL  = 2'h0;
  localparam out_fmt_t FMT_COUNTS   = 2'h1;
  localparam out_fmt_t FMT_EXPONENT = 2'h2;

  typedef enum logic [4:0] {
    CMD_FORMAT_SET, CMD_MASTER_KEY, CMD_ELEV_KEY, CMD_OFFSET_KEY, CMD_NULL_KEY,
    CMD_RFILTER_SET, CMD_SAVE, CMD_ELEV_SET, CMD_ELEV_ON, CMD_ELEV_OFF,
    CMD_SPAN_SET, CMD_TARE_SET, CMD_READ, CMD_RFILTER_Q, CMD_SPAN_Q,
    CMD_TARE_Q, CMD_ELEV_Q, CMD_OPTION_Q, CMD_TYPE_Q, CMD_RANGE_LOW_Q
  } cmd_e;
  typedef enum logic [1:0] {MODE_PRESSURE, MODE_RATE, MODE_PEAK} meas_mode_e;
  typedef enum logic [1:0] {OPT_NONE, OPT_SERIAL, OPT_DIGITAL, OPT_DIGITAL_ANALOG} option_e;
  typedef enum logic [2:0] {
    ERR_NONE, ERR_MASTER_OFF, ERR_OFFSET_OFF, ERR_ELEV_OFF, ERR_PARAM_INVALID
  } err_e;

  // bcd holds seven digits, most significant in the top nibble
  typedef struct packed {
    logic        neg;
    logic [2:0]  int_digits;
    logic [27:0] bcd;
  } field_s;
  typedef struct packed {
    field_s cur;
    field_s rate;
    field_s min;
    field_s max;
    field_s cnt_press;
    field_s cnt_temp;
    field_s range_low;
  } readings_s;
  typedef struct packed {
    out_fmt_t fmt;
    field_s   rfilter;
    field_s   span;
    field_s   tare;
    field_s   elev;
    logic     elev_apply;
  } settings_s;

  localparam logic [3:0]  DEC_DIGITS   = 4'h6;
  localparam logic [3:0]  CNT_DIGITS   = 4'h7;
  localparam logic [3:0]  EXP_LEN      = 4'hc;
  localparam logic [23:0] SPAN_MIN_BCD = 24'h090000;
  localparam logic [23:0] SPAN_MAX_BCD = 24'h110000;
  localparam logic [23:0] TARE_MAX_BCD = 24'h170000;
  localparam logic [2:0]  RFILTER_INT  = 3'h2;
  localparam field_s ZERO_FIELD = '{neg: 1'b0, int_digits: 3'h1, bcd: 28'h0};
  localparam field_s SPAN_RST   = '{neg: 1'b0, int_digits: 3'h1, bcd: 28'h1000000};
  localparam settings_s CFG_RST = '{fmt: FMT_DECIMAL, rfilter: ZERO_FIELD,
    span: SPAN_RST, tare: ZERO_FIELD, elev: ZERO_FIELD, elev_apply: 1'b0};

  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_MINUS = 8'h2d;
  localparam logic [7:0] CHAR_PLUS  = 8'h2b;
  localparam logic [7:0] CHAR_POINT = 8'h2e;
  localparam logic [7:0] CHAR_EXP   = 8'h45;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
endpackage

// ---- hdl/field_text.sv ----
// renders one numeric field as ascii, one character per index
`timescale 1ns/1ps
module field_text (
  input  wire gauge_cmd_pkg::field_s   fld_i,
  input  wire gauge_cmd_pkg::out_fmt_t fmt_i,
  input  wire logic [3:0]              idx_i,
  output logic [7:0]                   char_o,
  output logic                         last_o
);
  function automatic logic [7:0] dig(input logic [27:0] b, input logic [3:0] k);
    logic [27:0] s;
    s = b << {k, 2'b00};
    dig = gauge_cmd_pkg::CHAR_ZERO | {4'h0, s[27:24]};
  endfunction

  always_comb begin
    logic [3:0] nd;
    logic [3:0] p;
    logic [3:0] j;
    logic [3:0] len;
    logic [3:0] sg;
    sg = {3'h0, fld_i.neg};
    nd = gauge_cmd_pkg::DEC_DIGITS - sg;
    p = ({1'b0, fld_i.int_digits} > nd) ? nd : {1'b0, fld_i.int_digits};
    j = idx_i - sg;
    len = sg + nd + {3'h0, p < nd};
    char_o = gauge_cmd_pkg::CHAR_ZERO;
    last_o = 1'b0;
    unique case (fmt_i)
      gauge_cmd_pkg::FMT_COUNTS: begin
        char_o = dig(fld_i.bcd, idx_i);
        last_o = (idx_i == gauge_cmd_pkg::CNT_DIGITS - 4'h1);
      end
      gauge_cmd_pkg::FMT_EXPONENT: begin
        // sign always present, so negatives keep all six digits
        last_o = (idx_i == gauge_cmd_pkg::EXP_LEN - 4'h1);
        if (idx_i == 4'h0)
          char_o = fld_i.neg ? gauge_cmd_pkg::CHAR_MINUS : gauge_cmd_pkg::CHAR_PLUS;
        else if (idx_i == 4'h1)
          char_o = dig(fld_i.bcd, 4'h0);
        else if (idx_i == 4'h2)
          char_o = gauge_cmd_pkg::CHAR_POINT;
        else if (idx_i <= 4'h7)
          char_o = dig(fld_i.bcd, idx_i - 4'h2);
        else if (idx_i == 4'h8)
          char_o = gauge_cmd_pkg::CHAR_EXP;
        else if (idx_i == 4'h9)
          char_o = gauge_cmd_pkg::CHAR_PLUS;
        else if (idx_i == 4'ha)
          char_o = gauge_cmd_pkg::CHAR_ZERO;
        else
          char_o = gauge_cmd_pkg::CHAR_ZERO + {5'h0, fld_i.int_digits} - 8'h01;
      end
      default: begin
        last_o = (idx_i == len - 4'h1);
        if (fld_i.neg && idx_i == 4'h0)
          char_o = gauge_cmd_pkg::CHAR_MINUS;
        else if (j < p)
          char_o = dig(fld_i.bcd, j);
        else if (j == p)
          char_o = gauge_cmd_pkg::CHAR_POINT;
        else
          char_o = dig(fld_i.bcd, j - 4'h1);
      end
    endcase
  end
endmodule

// ---- tb/resp_reader.sv ----
// partner model: remote reader that collects answer characters
`timescale 1ns/1ps
module resp_reader (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o
);
  logic [7:0] seen[$];
  logic       tick_q = 1'b0;
  always @(posedge clk_i) begin
    if (valid_i && ready_o) seen.push_back(data_i);
    tick_q <= ~tick_q;
  end
  // slow reader stalls every other cycle to stretch the answer
  assign ready_o = !slow_i || tick_q;
endmodule

// ---- tb/test_remote_command_parser.sv ----
// self-checking bench of the remote command interpreter
`timescale 1ns/1ps
module test_remote_command_parser;
  logic ref_clk_i = 0, rst_i = 1, cmd_valid_i = 0, slow = 0, resp_ready_i;
  logic error_i = 0, default_i = 0, dev_clear_i = 0, sel_clear_i = 0, power_up_i = 0;
  logic span_sw_i = 0, elev_sw_i = 0, null_sw_i = 0, units_metric_i = 0, sensor_abs_i = 1;
  gauge_cmd_pkg::cmd_e       cmd_i = gauge_cmd_pkg::CMD_READ;
  gauge_cmd_pkg::field_s     arg_i = gauge_cmd_pkg::ZERO_FIELD;
  gauge_cmd_pkg::option_e    option_i = gauge_cmd_pkg::OPT_SERIAL;
  gauge_cmd_pkg::meas_mode_e mode_i = gauge_cmd_pkg::MODE_PRESSURE;
  gauge_cmd_pkg::readings_s  readings_i = '0;
  gauge_cmd_pkg::settings_s  settings_o;
  gauge_cmd_pkg::err_e       err_code_o;
  logic cmd_ready_o, elev_metric_o, master_en_o, elev_en_o, offset_en_o, null_en_o;
  logic elev_disabled_o, err_o, save_o, resp_valid_o;
  logic [7:0] resp_data_o;
  int err_total = 0, checked = 0;
  remote_command_parser i_remote_command_parser (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_i,
    .arg_i, .cmd_ready_o, .error_i, .default_i, .dev_clear_i, .sel_clear_i, .power_up_i,
    .span_sw_i, .elev_sw_i, .null_sw_i, .units_metric_i, .sensor_abs_i, .option_i, .mode_i,
    .readings_i, .settings_o, .elev_metric_o, .master_en_o, .elev_en_o, .offset_en_o,
    .null_en_o, .elev_disabled_o, .err_o, .err_code_o, .save_o, .resp_data_o, .resp_valid_o,
    .resp_ready_i);
  resp_reader i_resp_reader (.clk_i(ref_clk_i), .slow_i(slow), .valid_i(resp_valid_o),
    .data_i(resp_data_o), .ready_o(resp_ready_i));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held from a falling edge through the taking rising edge
  task automatic cmd(input gauge_cmd_pkg::cmd_e c, input logic [3:0] d = 4'h1);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    cmd_i = c;
    arg_i.bcd = {d, 24'h0};
    cmd_valid_i = 1;
    while (cmd_ready_o !== 1'b1 && n < 600) begin
      n++;
      @(negedge ref_clk_i);
    end
    if (n == 600) begin
      err_total++;
      give_verdict();
    end
    @(negedge ref_clk_i);
    cmd_valid_i = 0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1;
    @(negedge ref_clk_i);
    s = 0;
  endtask
  task automatic ans(input gauge_cmd_pkg::cmd_e c, input string s);
    int n;
    n = 0;
    i_resp_reader.seen.delete();
    cmd(c);
    while (!(i_resp_reader.seen.size() > 0 && i_resp_reader.seen[$] == 8'h0a) && n < 600) begin
      n++;
      @(negedge ref_clk_i);
    end
    if (n == 600) begin
      err_total++;
      give_verdict();
    end
    s = {s, "\015\012"};
    chk(i_resp_reader.seen.size(), s.len());
    foreach (i_resp_reader.seen[i]) chk(i_resp_reader.seen[i], s[i]);
  endtask
  initial forever #10 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 0;
    chk(settings_o.fmt, gauge_cmd_pkg::FMT_DECIMAL);
    cmd(gauge_cmd_pkg::CMD_MASTER_KEY);
    chk(master_en_o, 0);
    span_sw_i = 1;
    cmd(gauge_cmd_pkg::CMD_MASTER_KEY);
    chk(master_en_o, 1);
    span_sw_i = 0;
    @(negedge ref_clk_i);
    chk(master_en_o, 0);
    cmd(gauge_cmd_pkg::CMD_SPAN_SET);
    chk(err_code_o, gauge_cmd_pkg::ERR_MASTER_OFF);
    cmd(gauge_cmd_pkg::CMD_ELEV_SET);
    chk(elev_disabled_o, 1);
    elev_sw_i = 1;
    cmd(gauge_cmd_pkg::CMD_ELEV_KEY);
    chk(elev_en_o, 1);
    pulse(error_i);
    chk(elev_en_o, 0);
    cmd(gauge_cmd_pkg::CMD_OFFSET_KEY);
    chk(offset_en_o, 1);
    pulse(dev_clear_i);
    chk(offset_en_o, 0);
    null_sw_i = 1;
    cmd(gauge_cmd_pkg::CMD_NULL_KEY);
    null_sw_i = 0;
    chk(null_en_o, 1);
    pulse(sel_clear_i);
    chk(null_en_o, 0);
    cmd(gauge_cmd_pkg::CMD_FORMAT_SET, 4'h1);
    cmd(gauge_cmd_pkg::CMD_SAVE);
    cmd(gauge_cmd_pkg::CMD_FORMAT_SET, 4'h2);
    chk(settings_o.fmt, gauge_cmd_pkg::FMT_EXPONENT);
    pulse(power_up_i);
    chk(settings_o.fmt, gauge_cmd_pkg::FMT_COUNTS);
    slow = 1;
    ans(gauge_cmd_pkg::CMD_TYPE_Q, "ABSOLUTE PRESSURE");
    ans(gauge_cmd_pkg::CMD_OPTION_Q, "SERIAL");
    readings_i.cnt_press.bcd = 28'h1234567;
    readings_i.cnt_temp.bcd = 28'h8901234;
    ans(gauge_cmd_pkg::CMD_READ, "1234567, 8901234");
    cmd(gauge_cmd_pkg::CMD_FORMAT_SET, 4'h0);
    mode_i = gauge_cmd_pkg::MODE_PEAK;
    readings_i.min = '{neg: 1'b1, int_digits: 3'h2, bcd: 28'h1432100};
    readings_i.cur = '{neg: 1'b0, int_digits: 3'h2, bcd: 28'h1434560};
    readings_i.max = '{neg: 1'b0, int_digits: 3'h2, bcd: 28'h1445670};
    ans(gauge_cmd_pkg::CMD_READ, "-14.321, 14.3456, 14.4567");
    cmd(gauge_cmd_pkg::CMD_FORMAT_SET, 4'h2);
    mode_i = gauge_cmd_pkg::MODE_PRESSURE;
    ans(gauge_cmd_pkg::CMD_READ, "+1.43456E+01");
    cmd(gauge_cmd_pkg::CMD_OFFSET_KEY);
    cmd(gauge_cmd_pkg::CMD_TARE_SET, 4'h5);
    ans(gauge_cmd_pkg::CMD_TARE_Q, "5.00000");
    span_sw_i = 1;
    cmd(gauge_cmd_pkg::CMD_MASTER_KEY);
    cmd(gauge_cmd_pkg::CMD_SPAN_SET, 4'h2);
    chk(settings_o.span.bcd, 28'h1100000);
    cmd(gauge_cmd_pkg::CMD_ELEV_ON);
    chk(settings_o.elev_apply, 1);
    ans(gauge_cmd_pkg::CMD_ELEV_Q, "0.00000 FEET");
    give_verdict();
  end
endmodule
